// file: dv/spl_i2c_host.sv
// serial-bus host model driving clock and data toward the register bank
// assumes data wire resolved outside with a pull-up; o_sda high releases
`timescale 1ns/1ps
`default_nettype none

module spl_i2c_host (
    input wire logic i_sys_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic half();
        repeat (8) @(negedge i_sys_clk);
    endtask

    task automatic start();
        o_sda = 1'b1;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b0;
        half();
        o_scl = 1'b0;
    endtask

    task automatic stop();
        o_sda = 1'b0;
        half();
        o_scl = 1'b1;
        half();
        o_sda = 1'b1;
        half();
    endtask

    // nine bits msb first; the line is sampled before each clock fall
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            o_sda = tx[i];
            half();
            o_scl = 1'b1;
            half();
            rx[i] = i_sda;
            o_scl = 1'b0;
        end
    endtask

    task automatic wr_reg(input logic [3:0] strap, input logic [7:0] ptr, input logic [7:0] data, output logic ok);
        logic [8:0] a;
        logic [8:0] p;
        logic [8:0] d;
        start();
        byte_io({3'h5, strap, 2'b01}, a);
        byte_io({ptr, 1'b1}, p);
        byte_io({data, 1'b1}, d);
        stop();
        ok = !a[0] && !p[0] && !d[0];
    endtask

    // pointer write, repeated start, one byte read then no-acknowledge
    task automatic rd_reg(input logic [3:0] strap, input logic [7:0] ptr, output logic [7:0] data, output logic ok);
        logic [8:0] a;
        logic [8:0] p;
        logic [8:0] b;
        logic [8:0] d;
        start();
        byte_io({3'h5, strap, 2'b01}, a);
        byte_io({ptr, 1'b1}, p);
        start();
        byte_io({3'h5, strap, 2'b11}, b);
        byte_io(9'h1ff, d);
        stop();
        data = d[8:1];
        ok = !a[0] && !p[0] && !b[0];
    endtask
endmodule
`default_nettype wire

// file: dv/splitter_i2c_config_regs_test.sv
// self-checking bench of the serial configuration register bank
// assumes the host model in spl_i2c_host.sv and a pulled-up data wire
`timescale 1ns/1ps
`default_nettype none

module splitter_i2c_config_regs_test;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_control_mode_select = 1'b1;
    logic i_clk_level_ok = 1'b1;
    logic [3:0] i_addr_strap = 4'h9;
    logic o_sda;
    logic o_sda_oe_n;
    logic host_scl;
    logic host_sda;
    logic ok;
    spl_pkg::spl_ctl_t o_ctl;
    wire logic sda_line;
    int error_cnt = 0;
    int tests_run = 0;
    logic [7:0] sh [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'h00};
    logic [31:0] vec [4] = '{32'ha0f4d710, 32'h30024b8e, 32'h90683c61, 32'hf05e2972};

    assign sda_line = host_sda & (o_sda_oe_n | o_sda);

    initial begin
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    spl_i2c_regs spl_i2c_regs_inst (.i_sys_clk, .i_rst_n, .i_scl(host_scl), .i_sda(sda_line), .i_addr_strap,
        .i_control_mode_select, .i_clk_level_ok, .o_sda, .o_sda_oe_n, .o_ctl);
    spl_i2c_host spl_i2c_host_inst (.i_sys_clk, .i_sda(sda_line), .o_scl(host_scl), .o_sda(host_sda));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic wok;
        spl_i2c_host_inst.wr_reg(i_addr_strap, p, d, wok);
        chk(32'(wok), 32'h1);
        if (p < 8'h08) begin
            sh[p[2:0]] = d;
        end
    endtask

    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic rok;
        logic [7:0] d;
        spl_i2c_host_inst.rd_reg(i_addr_strap, p, d, rok);
        chk({23'h0, rok, d}, {23'h0, 1'b1, e});
    endtask

    function automatic spl_pkg::spl_port_cfg_t eport(input logic [7:0] v, input logic en);
        eport.drv_en = en;
        eport.dbl_term = v[7];
        eport.emph_level = v[6] ? 3'h4 : v[6:4];
        eport.swing = v[3:2];
        eport.slew_level = {v[1] & v[0], v[1] ^ v[0]};
    endfunction

    // pin mode falls back to power-up contents
    function automatic spl_pkg::spl_ctl_t ectl();
        logic [7:0] g;
        logic [7:0] r;
        g = i_control_mode_select ? sh[0] : 8'hff;
        r = i_control_mode_select ? sh[1] : 8'h00;
        ectl.serial_ctl = i_control_mode_select;
        ectl.equalizer_on = g[7];
        ectl.term_pd_connect = !r[7];
        ectl.bias_ctl_en = r[5];
        ectl.bias_vdd = r[6] && r[5];
        ectl.equalizer_gain = r[4:2];
        ectl.squelch_on = !r[1];
        ectl.squelched = !r[1] && !i_clk_level_ok;
        ectl.port1 = eport(i_control_mode_select ? sh[3] : 8'h00, g[7] && g[5] && !ectl.squelched);
        ectl.port2 = eport(i_control_mode_select ? sh[4] : 8'h00, g[7] && g[4] && !ectl.squelched);
    endfunction

    initial begin
        repeat (60000) @(posedge i_sys_clk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        for (int i = 0; i < 8; i++) begin
            rd(8'(i), sh[i]);
        end
        chk(32'(o_ctl), 32'(ectl()));
        $display("test power-up values done");
        for (int i = 0; i < 9; i++) begin
            wr(8'(i), {3'(i), 5'h15});
            rd(8'(i), i < 8 ? {3'(i), 5'h15} : 8'h00);
        end
        chk(32'(o_ctl), 32'(ectl()));
        $display("test register storage done");
        spl_i2c_host_inst.wr_reg(i_addr_strap ^ 4'h1, 8'h00, 8'h00, ok);
        chk(32'(ok), 32'h0);
        rd(8'h00, sh[0]);
        $display("test foreign address done");
        foreach (vec[k]) begin
            wr(8'h00, vec[k][31:24]);
            wr(8'h01, vec[k][23:16]);
            wr(8'h03, vec[k][15:8]);
            wr(8'h04, vec[k][7:0]);
            for (int l = 1; l >= 0; l--) begin
                i_clk_level_ok = l[0];
                repeat (5) @(negedge i_sys_clk);
                chk(32'(o_ctl), 32'(ectl()));
            end
            i_clk_level_ok = 1'b1;
        end
        $display("test control decode done");
        i_control_mode_select = 1'b0;
        repeat (5) @(negedge i_sys_clk);
        chk(32'(o_ctl), 32'(ectl()));
        rd(8'h03, sh[3]);
        i_control_mode_select = 1'b1;
        repeat (5) @(negedge i_sys_clk);
        chk(32'(o_ctl), 32'(ectl()));
        $display("test mode select done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// file: src/spl_consts.svh
// constants of the splitter serial configuration register bank
// assumes inclusion by bare name from every file that needs them
`ifndef SPL_CONSTS_SVH
`define SPL_CONSTS_SVH

// device address: fixed prefix then four strap bits then read/write
`define SPL_ADDR_PREFIX 3'b101
`define SPL_BITS_PER_BYTE 4'h8
`define SPL_NUM_REGS 8
`define SPL_PTR_LIMIT 8'h08
`define SPL_READ_UNMAPPED 8'h00

// register offsets
`define SPL_OFF_GENERAL_CONFIG 3'h0
`define SPL_OFF_RECEIVER_SETTING 3'h1
`define SPL_OFF_RESERVED_TWO 3'h2
`define SPL_OFF_PORT_ONE_OUTPUT 3'h3
`define SPL_OFF_PORT_TWO_OUTPUT 3'h4
`define SPL_OFF_RESERVED_FIVE 3'h5
`define SPL_OFF_RESERVED_SIX 3'h6
`define SPL_OFF_RESERVED_SEVEN 3'h7

// power-up values
`define SPL_RST_GENERAL_CONFIG 8'hff
`define SPL_RST_RECEIVER_SETTING 8'h00
`define SPL_RST_RESERVED_TWO 8'h00
`define SPL_RST_PORT_ONE_OUTPUT 8'h00
`define SPL_RST_PORT_TWO_OUTPUT 8'h00
`define SPL_RST_RESERVED_FIVE 8'h00
`define SPL_RST_RESERVED_SIX 8'h0f
`define SPL_RST_RESERVED_SEVEN 8'h00

// general configuration fields
`define SPL_GC_NORMAL_BIT 7
`define SPL_GC_PORT1_EN_BIT 5
`define SPL_GC_PORT2_EN_BIT 4
// receiver setting fields
`define SPL_RS_TERM_OFF_BIT 7
`define SPL_RS_BIAS_VDD_BIT 6
`define SPL_RS_BIAS_CTL_BIT 5
`define SPL_RS_GAIN_MSB 4
`define SPL_RS_GAIN_LSB 2
`define SPL_RS_SQUELCH_OFF_BIT 1
// port output fields
`define SPL_PO_DBL_TERM_BIT 7
`define SPL_PO_EMPH_MSB 6
`define SPL_PO_EMPH_LSB 4
`define SPL_PO_SWING_MSB 3
`define SPL_PO_SWING_LSB 2
`define SPL_PO_SLEW_MSB 1
`define SPL_PO_SLEW_LSB 0
// pre-emphasis level code for any 1xx field value
`define SPL_EMPH_6DB 3'h4

// idle level of synchronised pins: clock and data high
`define SPL_PIN_IDLE 8'hc0

`endif

// file: src/spl_ctrl_decode.sv
// turns register contents into registered analog control levels
// assumes synchronised mode and clock-level inputs on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "spl_consts.svh"

module spl_ctrl_decode (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_general_config,
    input wire logic [7:0] i_receiver_setting,
    input wire logic [7:0] i_port_one_output,
    input wire logic [7:0] i_port_two_output,
    input wire logic i_serial_mode,
    input wire logic i_clk_level_ok,
    output spl_pkg::spl_ctl_t o_ctl
);

    spl_pkg::spl_ctl_t st_ff;
    spl_pkg::spl_ctl_t nxt_st;

    function automatic spl_pkg::spl_port_cfg_t port_cfg(input logic [7:0] b, input logic en);
        spl_pkg::spl_port_cfg_t p;
        logic [2:0] e;
        logic [1:0] s;
        e = b[`SPL_PO_EMPH_MSB:`SPL_PO_EMPH_LSB];
        s = b[`SPL_PO_SLEW_MSB:`SPL_PO_SLEW_LSB];
        p.drv_en = en;
        p.dbl_term = b[`SPL_PO_DBL_TERM_BIT];
        p.emph_level = e[2] ? `SPL_EMPH_6DB : e;
        p.swing = b[`SPL_PO_SWING_MSB:`SPL_PO_SWING_LSB];
        p.slew_level = (s == 2'h3) ? 2'h2 : {1'b0, |s};
        return p;
    endfunction

    always_comb begin
        logic [7:0] gc;
        logic [7:0] rs;
        logic [7:0] p1;
        logic [7:0] p2;
        logic normal;
        gc = i_serial_mode ? i_general_config : `SPL_RST_GENERAL_CONFIG;
        rs = i_serial_mode ? i_receiver_setting : `SPL_RST_RECEIVER_SETTING;
        p1 = i_serial_mode ? i_port_one_output : `SPL_RST_PORT_ONE_OUTPUT;
        p2 = i_serial_mode ? i_port_two_output : `SPL_RST_PORT_TWO_OUTPUT;
        normal = gc[`SPL_GC_NORMAL_BIT];
        nxt_st.serial_ctl = i_serial_mode;
        nxt_st.equalizer_on = normal;
        nxt_st.term_pd_connect = !rs[`SPL_RS_TERM_OFF_BIT];
        nxt_st.bias_ctl_en = rs[`SPL_RS_BIAS_CTL_BIT];
        nxt_st.bias_vdd = rs[`SPL_RS_BIAS_CTL_BIT] & rs[`SPL_RS_BIAS_VDD_BIT];
        nxt_st.equalizer_gain = rs[`SPL_RS_GAIN_MSB:`SPL_RS_GAIN_LSB];
        nxt_st.squelch_on = !rs[`SPL_RS_SQUELCH_OFF_BIT];
        nxt_st.squelched = !rs[`SPL_RS_SQUELCH_OFF_BIT] & !i_clk_level_ok;
        nxt_st.port1 = port_cfg(p1, normal & gc[`SPL_GC_PORT1_EN_BIT] & !nxt_st.squelched);
        nxt_st.port2 = port_cfg(p2, normal & gc[`SPL_GC_PORT2_EN_BIT] & !nxt_st.squelched);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_ctl = st_ff;

endmodule
`default_nettype wire

// file: src/spl_i2c_regs.sv
// serial-bus configuration register bank of a one-in two-out splitter
// assumes open-drain clock and data lines resolved outside; strap and mode pins static
//
// Functional notes
// - answer address 101 plus four strap bits; low bit one reads, zero writes
// - general config bit 7: one normal, zero standby powering down equalizer and drivers
// - general config bit 5 enables output port 1
// - general config bit 4 enables output port 2
// - receiver setting bit 7 one disconnects input termination pull-downs
// - receiver bit 6 picks bias ground or supply, only while bit 5 is one
// - receiver bits 4 to 2 select equalizer gain 2.5 to 20 dB
// - receiver bit 1 zero enables squelch, one disables it
// - offset 3 holds port 1 settings; bit 7 one means double termination
// - offset 4 holds port 2 settings, same layout, resets to zero
// - pre-emphasis bits 6 to 4: 0, 1.5, 2.5, 3.5 dB; top bit gives 6 dB
// - swing bits 3 to 2: nominal, minus ten, plus ten, plus twenty percent
// - slew bits 1 to 0: default, plus five twice, plus ten percent
// - squelch on and input clock level low disables both output ports
`timescale 1ns/1ps
`default_nettype none
`include "spl_consts.svh"

module spl_i2c_regs (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic [3:0] i_addr_strap,
    input wire logic i_control_mode_select,
    input wire logic i_clk_level_ok,
    output logic o_sda,
    output logic o_sda_oe_n,
    output spl_pkg::spl_ctl_t o_ctl
);

    spl_pkg::spl_pins_t pins_raw;
    spl_pkg::spl_pins_t pins;
    spl_pkg::spl_i2c_state_t st_ff;
    spl_pkg::spl_i2c_state_t nxt_st;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic byte_done;
    logic addr_hit;
    logic ptr_ok;
    logic [7:0] rd_byte;

    assign pins_raw.scl = i_scl;
    assign pins_raw.sda = i_sda;
    assign pins_raw.addr_strap = i_addr_strap;
    assign pins_raw.control_mode_select = i_control_mode_select;
    assign pins_raw.clk_level_ok = i_clk_level_ok;

    spl_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_pins(pins_raw),
        .o_pins(pins)
    );

    assign scl_rise = pins.scl & !st_ff.scl_q;
    assign scl_fall = !pins.scl & st_ff.scl_q;
    assign start_seen = pins.scl & st_ff.scl_q & st_ff.sda_q & !pins.sda;
    assign stop_seen = pins.scl & st_ff.scl_q & !st_ff.sda_q & pins.sda;
    assign byte_done = (st_ff.cnt == `SPL_BITS_PER_BYTE);
    assign addr_hit = (st_ff.shift[7:5] == `SPL_ADDR_PREFIX) && (st_ff.shift[4:1] == pins.addr_strap);
    assign ptr_ok = (st_ff.ptr < `SPL_PTR_LIMIT);
    assign rd_byte = ptr_ok ? st_ff.regs[st_ff.ptr[2:0]] : `SPL_READ_UNMAPPED;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.scl_q = pins.scl;
        nxt_st.sda_q = pins.sda;
        nxt_st.sda_o = 1'b0;
        if (start_seen) begin
            nxt_st.fsm = spl_pkg::SPL_ADDR;
            nxt_st.cnt = 4'h0;
            nxt_st.sda_oe_n = 1'b1;
        end else if (stop_seen) begin
            nxt_st.fsm = spl_pkg::SPL_IDLE;
            nxt_st.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            unique case (st_ff.fsm)
                spl_pkg::SPL_ADDR, spl_pkg::SPL_PTR, spl_pkg::SPL_WDATA: begin
                    nxt_st.shift = {st_ff.shift[6:0], pins.sda};
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end
                spl_pkg::SPL_RDATA: begin
                    nxt_st.cnt = st_ff.cnt + 4'h1;
                end
                spl_pkg::SPL_RDATA_ACK: begin
                    nxt_st.master_ack = !pins.sda;
                end
                spl_pkg::SPL_IDLE, spl_pkg::SPL_ADDR_ACK, spl_pkg::SPL_PTR_ACK,
                spl_pkg::SPL_WDATA_ACK: begin
                    nxt_st.cnt = st_ff.cnt;
                end
            endcase
        end else if (scl_fall) begin
            unique case (st_ff.fsm)
                spl_pkg::SPL_ADDR: begin
                    if (byte_done) begin
                        if (addr_hit) begin
                            nxt_st.fsm = spl_pkg::SPL_ADDR_ACK;
                            nxt_st.rw = st_ff.shift[0];
                            nxt_st.sda_oe_n = 1'b0;
                        end else begin
                            nxt_st.fsm = spl_pkg::SPL_IDLE;
                        end
                    end
                end
                spl_pkg::SPL_ADDR_ACK: begin
                    nxt_st.cnt = 4'h0;
                    if (st_ff.rw) begin
                        nxt_st.fsm = spl_pkg::SPL_RDATA;
                        nxt_st.shift = rd_byte;
                        nxt_st.sda_oe_n = rd_byte[7];
                    end else begin
                        nxt_st.fsm = spl_pkg::SPL_PTR;
                        nxt_st.sda_oe_n = 1'b1;
                    end
                end
                spl_pkg::SPL_PTR: begin
                    if (byte_done) begin
                        nxt_st.ptr = st_ff.shift;
                        nxt_st.fsm = spl_pkg::SPL_PTR_ACK;
                        nxt_st.sda_oe_n = 1'b0;
                    end
                end
                spl_pkg::SPL_PTR_ACK, spl_pkg::SPL_WDATA_ACK: begin
                    nxt_st.fsm = spl_pkg::SPL_WDATA;
                    nxt_st.cnt = 4'h0;
                    nxt_st.sda_oe_n = 1'b1;
                end
                spl_pkg::SPL_WDATA: begin
                    if (byte_done) begin
                        if (ptr_ok) begin
                            nxt_st.regs[st_ff.ptr[2:0]] = st_ff.shift;
                        end
                        nxt_st.ptr = st_ff.ptr + 8'h01;
                        nxt_st.fsm = spl_pkg::SPL_WDATA_ACK;
                        nxt_st.sda_oe_n = 1'b0;
                    end
                end
                spl_pkg::SPL_RDATA: begin
                    if (byte_done) begin
                        nxt_st.fsm = spl_pkg::SPL_RDATA_ACK;
                        nxt_st.ptr = st_ff.ptr + 8'h01;
                        nxt_st.sda_oe_n = 1'b1;
                    end else begin
                        nxt_st.shift = {st_ff.shift[6:0], 1'b0};
                        nxt_st.sda_oe_n = st_ff.shift[6];
                    end
                end
                spl_pkg::SPL_RDATA_ACK: begin
                    nxt_st.cnt = 4'h0;
                    if (st_ff.master_ack) begin
                        nxt_st.fsm = spl_pkg::SPL_RDATA;
                        nxt_st.shift = rd_byte;
                        nxt_st.sda_oe_n = rd_byte[7];
                    end else begin
                        nxt_st.fsm = spl_pkg::SPL_IDLE;
                    end
                end
                spl_pkg::SPL_IDLE: begin
                    nxt_st.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff.fsm <= spl_pkg::SPL_IDLE;
            st_ff.cnt <= 4'h0;
            st_ff.shift <= 8'h00;
            st_ff.ptr <= 8'h00;
            st_ff.rw <= 1'b0;
            st_ff.master_ack <= 1'b0;
            st_ff.scl_q <= 1'b1;
            st_ff.sda_q <= 1'b1;
            st_ff.sda_oe_n <= 1'b1;
            st_ff.sda_o <= 1'b0;
            st_ff.regs[`SPL_OFF_GENERAL_CONFIG] <= `SPL_RST_GENERAL_CONFIG;
            st_ff.regs[`SPL_OFF_RECEIVER_SETTING] <= `SPL_RST_RECEIVER_SETTING;
            st_ff.regs[`SPL_OFF_RESERVED_TWO] <= `SPL_RST_RESERVED_TWO;
            st_ff.regs[`SPL_OFF_PORT_ONE_OUTPUT] <= `SPL_RST_PORT_ONE_OUTPUT;
            st_ff.regs[`SPL_OFF_PORT_TWO_OUTPUT] <= `SPL_RST_PORT_TWO_OUTPUT;
            st_ff.regs[`SPL_OFF_RESERVED_FIVE] <= `SPL_RST_RESERVED_FIVE;
            st_ff.regs[`SPL_OFF_RESERVED_SIX] <= `SPL_RST_RESERVED_SIX;
            st_ff.regs[`SPL_OFF_RESERVED_SEVEN] <= `SPL_RST_RESERVED_SEVEN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    spl_ctrl_decode u_decode (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_general_config(st_ff.regs[`SPL_OFF_GENERAL_CONFIG]),
        .i_receiver_setting(st_ff.regs[`SPL_OFF_RECEIVER_SETTING]),
        .i_port_one_output(st_ff.regs[`SPL_OFF_PORT_ONE_OUTPUT]),
        .i_port_two_output(st_ff.regs[`SPL_OFF_PORT_TWO_OUTPUT]),
        .i_serial_mode(pins.control_mode_select),
        .i_clk_level_ok(pins.clk_level_ok),
        .o_ctl(o_ctl)
    );

    assign o_sda = st_ff.sda_o;
    assign o_sda_oe_n = st_ff.sda_oe_n;

    // checks
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic [7:0] gc_r;
    logic [7:0] rs_r;
    logic [7:0] p1_r;
    logic [7:0] p2_r;
    logic mode_r;
    assign gc_r = st_ff.regs[`SPL_OFF_GENERAL_CONFIG];
    assign rs_r = st_ff.regs[`SPL_OFF_RECEIVER_SETTING];
    assign p1_r = st_ff.regs[`SPL_OFF_PORT_ONE_OUTPUT];
    assign p2_r = st_ff.regs[`SPL_OFF_PORT_TWO_OUTPUT];
    assign mode_r = pins.control_mode_select;

    a_addr_ack_match: assert property ((st_ff.fsm == spl_pkg::SPL_ADDR) && byte_done && scl_fall
        && !start_seen && !stop_seen
        |=> (st_ff.fsm == spl_pkg::SPL_ADDR_ACK) == $past(addr_hit) && (!o_sda_oe_n == $past(addr_hit)))
        else $error("address acknowledge does not follow address match");
    a_standby_power_down: assert property (mode_r && !gc_r[`SPL_GC_NORMAL_BIT]
        |=> !o_ctl.equalizer_on && !o_ctl.port1.drv_en && !o_ctl.port2.drv_en)
        else $error("standby left equalizer or drivers on");
    a_normal_on: assert property (mode_r && gc_r[`SPL_GC_NORMAL_BIT] |=> o_ctl.equalizer_on)
        else $error("equalizer off in normal operation");
    a_port1_disable: assert property (mode_r && !gc_r[`SPL_GC_PORT1_EN_BIT] |=> !o_ctl.port1.drv_en)
        else $error("port 1 driven while disabled");
    a_port1_enable: assert property (mode_r && gc_r[`SPL_GC_NORMAL_BIT] && gc_r[`SPL_GC_PORT1_EN_BIT]
        && rs_r[`SPL_RS_SQUELCH_OFF_BIT] |=> o_ctl.port1.drv_en)
        else $error("port 1 not driven while enabled");
    a_port2_disable: assert property (mode_r && !gc_r[`SPL_GC_PORT2_EN_BIT] |=> !o_ctl.port2.drv_en)
        else $error("port 2 driven while disabled");
    a_port2_enable: assert property (mode_r && gc_r[`SPL_GC_NORMAL_BIT] && gc_r[`SPL_GC_PORT2_EN_BIT]
        && rs_r[`SPL_RS_SQUELCH_OFF_BIT] |=> o_ctl.port2.drv_en)
        else $error("port 2 not driven while enabled");
    a_term_pulldown: assert property (mode_r
        |=> o_ctl.term_pd_connect == !$past(rs_r[`SPL_RS_TERM_OFF_BIT]))
        else $error("termination pull-down does not follow its bit");
    a_bias_gated: assert property (mode_r && !rs_r[`SPL_RS_BIAS_CTL_BIT] |=> !o_ctl.bias_vdd)
        else $error("bias selection acted while not enabled");
    a_bias_select: assert property (mode_r && rs_r[`SPL_RS_BIAS_CTL_BIT]
        |=> o_ctl.bias_vdd == $past(rs_r[`SPL_RS_BIAS_VDD_BIT]))
        else $error("bias selection ignored while enabled");
    a_gain_follows: assert property (mode_r
        |=> o_ctl.equalizer_gain == $past(rs_r[`SPL_RS_GAIN_MSB:`SPL_RS_GAIN_LSB]))
        else $error("equalizer gain does not follow its field");
    a_squelch_off: assert property (mode_r && !rs_r[`SPL_RS_SQUELCH_OFF_BIT] && !pins.clk_level_ok
        |=> o_ctl.squelched && !o_ctl.port1.drv_en && !o_ctl.port2.drv_en)
        else $error("outputs active while squelched");
    a_squelch_clear: assert property (mode_r && pins.clk_level_ok |=> !o_ctl.squelched)
        else $error("squelch held with input clock present");
    a_squelch_bit: assert property (mode_r |=> o_ctl.squelch_on == !$past(rs_r[`SPL_RS_SQUELCH_OFF_BIT]))
        else $error("squelch enable does not follow its bit");
    a_port1_term: assert property (mode_r |=> o_ctl.port1.dbl_term == $past(p1_r[`SPL_PO_DBL_TERM_BIT]))
        else $error("port 1 output mode wrong");
    a_reset_values: assert property ($rose(i_rst_n)
        |-> st_ff.regs[`SPL_OFF_PORT_TWO_OUTPUT] == `SPL_RST_PORT_TWO_OUTPUT
        && st_ff.regs[`SPL_OFF_RESERVED_SIX] == `SPL_RST_RESERVED_SIX)
        else $error("register power-up value wrong");
    a_port2_fields: assert property (mode_r |=> o_ctl.port2.dbl_term == $past(p2_r[`SPL_PO_DBL_TERM_BIT])
        && o_ctl.port2.swing == $past(p2_r[`SPL_PO_SWING_MSB:`SPL_PO_SWING_LSB]))
        else $error("port 2 settings not decoded");
    a_emph_top: assert property (mode_r && p1_r[`SPL_PO_EMPH_MSB]
        |=> o_ctl.port1.emph_level == `SPL_EMPH_6DB)
        else $error("pre-emphasis top code not 6 dB");
    a_emph_low: assert property (mode_r && !p1_r[`SPL_PO_EMPH_MSB]
        |=> o_ctl.port1.emph_level == $past(p1_r[`SPL_PO_EMPH_MSB:`SPL_PO_EMPH_LSB]))
        else $error("pre-emphasis low code not passed");
    a_swing_slew: assert property (mode_r && p1_r[`SPL_PO_SLEW_MSB:`SPL_PO_SLEW_LSB] == 2'h3
        |=> o_ctl.port1.slew_level == 2'h2
        && o_ctl.port1.swing == $past(p1_r[`SPL_PO_SWING_MSB:`SPL_PO_SWING_LSB]))
        else $error("swing or slew level wrong");
    a_slew_mid: assert property (mode_r && ^p1_r[`SPL_PO_SLEW_MSB:`SPL_PO_SLEW_LSB]
        |=> o_ctl.port1.slew_level == 2'h1)
        else $error("slew middle codes not five percent");
    a_write_lands: assert property ((st_ff.fsm == spl_pkg::SPL_WDATA) && byte_done && scl_fall && ptr_ok
        && !start_seen && !stop_seen |=> st_ff.regs[$past(st_ff.ptr[2:0])] == $past(st_ff.shift)
        && st_ff.ptr == $past(st_ff.ptr) + 8'h01)
        else $error("register write lost or pointer not advanced");
    a_ptr_load: assert property ((st_ff.fsm == spl_pkg::SPL_PTR) && byte_done && scl_fall
        && !start_seen && !stop_seen |=> st_ff.ptr == $past(st_ff.shift))
        else $error("pointer byte not loaded");
    a_pin_mode: assert property (!mode_r |=> !o_ctl.serial_ctl && o_ctl.equalizer_on)
        else $error("registers acted outside serial-bus mode");

    c_write_byte: cover property ((st_ff.fsm == spl_pkg::SPL_WDATA_ACK) && scl_fall);
    c_read_byte: cover property ((st_ff.fsm == spl_pkg::SPL_RDATA_ACK) && scl_fall);
    c_squelch: cover property (o_ctl.squelched);
    c_standby: cover property (o_ctl.serial_ctl && !o_ctl.equalizer_on);
    c_pin_mode_read: cover property (!mode_r && (st_ff.fsm == spl_pkg::SPL_RDATA_ACK) && scl_fall);

endmodule
`default_nettype wire

// file: src/spl_pkg.sv
// types of the splitter serial configuration register bank
// assumes spl_consts.svh is not needed here: types only
package spl_pkg;

    typedef enum logic [8:0] {
        SPL_IDLE      = 9'h001,
        SPL_ADDR      = 9'h002,
        SPL_ADDR_ACK  = 9'h004,
        SPL_PTR       = 9'h008,
        SPL_PTR_ACK   = 9'h010,
        SPL_WDATA     = 9'h020,
        SPL_WDATA_ACK = 9'h040,
        SPL_RDATA     = 9'h080,
        SPL_RDATA_ACK = 9'h100
    } spl_fsm_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic [3:0] addr_strap;
        logic control_mode_select;
        logic clk_level_ok;
    } spl_pins_t;

    typedef struct packed {
        logic [7:0] meta;
        logic [7:0] stable;
    } spl_sync_state_t;

    typedef struct packed {
        logic drv_en;
        logic dbl_term;
        logic [2:0] emph_level;
        logic [1:0] swing;
        logic [1:0] slew_level;
    } spl_port_cfg_t;

    typedef struct packed {
        logic serial_ctl;
        logic equalizer_on;
        logic term_pd_connect;
        logic bias_ctl_en;
        logic bias_vdd;
        logic [2:0] equalizer_gain;
        logic squelch_on;
        logic squelched;
        spl_port_cfg_t port1;
        spl_port_cfg_t port2;
    } spl_ctl_t;

    typedef struct packed {
        spl_fsm_t fsm;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic rw;
        logic master_ack;
        logic scl_q;
        logic sda_q;
        logic sda_oe_n;
        logic sda_o;
        logic [7:0][7:0] regs;
    } spl_i2c_state_t;

endpackage

// file: src/spl_sync.sv
// two-flop synchroniser for the pins of the register bank
// assumes all inputs are asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "spl_consts.svh"

module spl_sync (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire spl_pkg::spl_pins_t i_pins,
    output spl_pkg::spl_pins_t o_pins
);

    spl_pkg::spl_sync_state_t st_ff;
    spl_pkg::spl_sync_state_t nxt_st;

    always_comb begin
        nxt_st.meta = i_pins;
        nxt_st.stable = st_ff.meta;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_ff.meta <= `SPL_PIN_IDLE;
            st_ff.stable <= `SPL_PIN_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_pins = st_ff.stable;

endmodule
`default_nettype wire
